/* File: hdl/scm_ctrl.v */
// System clock selection and power operating mode controller with an AHB-Lite slave.
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.vh"

module scm_ctrl (
    input  wire        ref_clk,        // System clock, 200 MHz.
    input  wire        srst,           // Synchronous reset, active high.
    input  wire        clk_en,         // Clock enable; freezes all state when low.
    input  wire        hsel,           // AHB-Lite slave select.
    input  wire [31:0] haddr,          // AHB-Lite address.
    input  wire [1:0]  htrans,         // AHB-Lite transfer type.
    input  wire        hwrite,         // AHB-Lite write strobe.
    input  wire [2:0]  hsize,          // AHB-Lite transfer size.
    input  wire        hready,         // AHB-Lite bus ready.
    input  wire [31:0] hwdata,         // AHB-Lite write data.
    output reg  [31:0] hrdata,         // AHB-Lite read data.
    output reg         hreadyout,      // AHB-Lite slave ready.
    output reg         hresp,          // AHB-Lite response, always OKAY.
    input  wire        fast_osc_in,    // Fast RC oscillator output, asynchronous.
    input  wire        slow_osc_in,    // Slow RC oscillator output, asynchronous.
    input  wire        fast_stable_in, // Fast oscillator stable indication, asynchronous.
    input  wire        halt_req,       // One-cycle pulse: CPU executes halt.
    input  wire        wake_req,       // One-cycle pulse: wake-up event.
    output reg         fast_osc_on,    // Enable for the fast oscillator.
    output reg         slow_osc_on,    // Enable for the slow oscillator.
    output reg         sys_clk_en,     // System clock enable pulse.
    output reg         cpu_clk_en,     // CPU clock enable pulse.
    output reg         tbc_clk_en,     // Time-base clock enable pulse.
    output reg         wdt_clk_en,     // Watchdog clock enable pulse.
    output reg  [2:0]  op_mode,        // Current operating mode code.
    output reg         irq             // Interrupt, high while an unmasked event is set.
);

    // Switch sequencer states. A change of selection first counts whole periods of
    // the clock in effect, then waits for the fast source to settle if the target
    // needs it, and finally hands over on a tick of the target, so no period of the
    // system clock enable is shortened or stretched in the middle.
    localparam SW_IDLE  = 2'h0;
    localparam SW_COUNT = 2'h1;
    localparam SW_READY = 2'h2;
    localparam SW_ALIGN = 2'h3;

    // Register fields.
    reg        sel_hl_q;
    reg  [2:0] sel_cks_q;
    reg        idle_on_halt_enable_q;
    reg        idle_sysclk_keep_q;
    reg        wdt_enable_q;
    reg  [`SCM_EV_W-1:0] irq_stat_q;
    reg  [`SCM_EV_W-1:0] irq_mask_q;

    // Selection in effect and switching state.
    reg        act_hl_q;
    reg  [2:0] act_cks_q;
    reg  [1:0] sw_state_q;
    reg  [2:0] sw_cnt_q;

    // Synchronisers and edge detection.
    reg  [2:0] fast_sync_q;
    reg  [2:0] slow_sync_q;
    reg  [1:0] stable_sync_q;
    reg  [5:0] div_cnt_q;
    reg        slow_ready_q;
    reg        fast_ready_q;

    // Bus data-phase state.
    reg        dp_write_q;
    reg  [7:0] dp_addr_q;

    wire fast_tick = fast_sync_q[1] & ~fast_sync_q[2];
    wire slow_tick = slow_sync_q[1] & ~slow_sync_q[2];

    // Tick of a fast-derived or slow source for a given selection.
    function src_tick;
        input       hl;
        input [2:0] cks;
        input [5:0] cnt;
        input       ft;
        input       st;
        reg   [5:0] mask;
        begin
            mask = 6'h00;
            case (cks)
                3'h2:    mask = 6'h3f;
                3'h3:    mask = 6'h1f;
                3'h4:    mask = 6'h0f;
                3'h5:    mask = 6'h07;
                3'h6:    mask = 6'h03;
                default: mask = 6'h01;
            endcase
            if (hl) begin
                src_tick = ft;
            end else if (cks[2:1] == 2'b00) begin
                src_tick = st;
            end else begin
                src_tick = ft & ((cnt & mask) == mask);
            end
        end
    endfunction

    wire act_fast = act_hl_q | (act_cks_q[2:1] != 2'b00);
    wire tgt_fast = sel_hl_q | (sel_cks_q[2:1] != 2'b00);
    wire cur_tick = src_tick(act_hl_q, act_cks_q, div_cnt_q, fast_tick, slow_tick);
    wire tgt_tick = src_tick(sel_hl_q, sel_cks_q, div_cnt_q, fast_tick, slow_tick);
    wire sel_diff = (sel_hl_q != act_hl_q) | (sel_cks_q != act_cks_q);
    wire is_run   = (op_mode == `SCM_M_NORMAL) | (op_mode == `SCM_M_SLOW);
    wire sw_done  = (sw_state_q == SW_ALIGN) & tgt_tick;

    // Bus address phase.
    wire ap_valid = hsel & hready & htrans[1];
    wire ap_read  = ap_valid & ~hwrite;
    wire dp_wr    = dp_write_q;

    // Fast source counts as settled only while it is enabled, so a stale stable level
    // left in the synchroniser cannot report a source that was just switched off.
    wire fast_stable_ok = stable_sync_q[1] & fast_osc_on;

    // Events that set sticky status bits.
    wire [`SCM_EV_W-1:0] ev;
    assign ev[`SCM_EV_SWITCH]   = sw_done;
    assign ev[`SCM_EV_FAST_RDY] = fast_stable_ok & ~fast_ready_q;
    assign ev[`SCM_EV_WAKE]     = wake_req & ~is_run;

    // Clock mode control register image; bit four reads zero.
    wire [7:0] mode_img = {sel_cks_q, 1'b0, slow_ready_q, fast_ready_q,
                           idle_on_halt_enable_q, sel_hl_q};
    wire [7:0] mode1_img = {idle_sysclk_keep_q, 6'h00, wdt_enable_q};
    wire [7:0] state_img = {3'h0, (sw_state_q != SW_IDLE), act_fast, op_mode};

    // Oscillator synchronisers and fast divider.
    // Both oscillator waves and the stable level are asynchronous to ref_clk, so each
    // passes two flip-flops before any logic looks at it. A tick is the rising edge
    // seen between the second and third stage; the divider counts fast ticks only.
    always @(posedge ref_clk) begin
        if (srst) begin
            fast_sync_q   <= 3'h0;
            slow_sync_q   <= 3'h0;
            stable_sync_q <= 2'h0;
            div_cnt_q     <= 6'h00;
        end else if (clk_en) begin
            fast_sync_q   <= {fast_sync_q[1:0], fast_osc_in};
            slow_sync_q   <= {slow_sync_q[1:0], slow_osc_in};
            stable_sync_q <= {stable_sync_q[0], fast_stable_in};
            if (fast_tick) begin
                div_cnt_q <= div_cnt_q + 6'h01;
            end
        end
    end

    // Ready flags of both oscillators.
    // The fast flag follows the settled level and falls as soon as the fast source
    // is disabled. The slow flag is cleared while the slow source is stopped and
    // rises on its first tick after restart, within one slow period.
    always @(posedge ref_clk) begin
        if (srst) begin
            fast_ready_q <= 1'b0;
            slow_ready_q <= 1'b0;
        end else if (clk_en) begin
            fast_ready_q <= fast_stable_ok;
            if (!slow_osc_on) begin
                slow_ready_q <= 1'b0;
            end else if (slow_tick) begin
                slow_ready_q <= 1'b1;
            end
        end
    end

    // Source switch sequencer: count current periods, wait ready, align to target.
    // The first tick of the current clock only aligns the count, so the four whole
    // periods that follow are never cut short by a switch requested mid-period.
    // A rewrite of the selection during a switch simply retargets the later steps.
    always @(posedge ref_clk) begin
        if (srst) begin
            sw_state_q <= SW_IDLE;
            sw_cnt_q   <= 3'h0;
            act_hl_q   <= `SCM_RST_HL;
            act_cks_q  <= `SCM_RST_CKS;
        end else if (clk_en) begin
            case (sw_state_q)
                SW_IDLE: begin
                    sw_cnt_q <= 3'h0;
                    if (sel_diff && !dp_wr) begin
                        sw_state_q <= SW_COUNT;
                    end
                end
                SW_COUNT: begin
                    if (cur_tick) begin
                        sw_cnt_q <= sw_cnt_q + 3'h1;
                        if (sw_cnt_q == `SCM_SWITCH_TICKS) begin
                            sw_state_q <= SW_READY;
                        end
                    end
                end
                SW_READY: begin
                    if (!tgt_fast || fast_ready_q) begin
                        sw_state_q <= SW_ALIGN;
                    end
                end
                SW_ALIGN: begin
                    if (tgt_tick) begin
                        act_hl_q   <= sel_hl_q;
                        act_cks_q  <= sel_cks_q;
                        sw_state_q <= SW_IDLE;
                    end
                end
                default: begin
                    sw_state_q <= SW_IDLE;
                end
            endcase
        end
    end

    // Operating mode: halt enters idle or sleep, wake returns to a run mode.
    // A halt request is honoured only in the run modes and a wake request only in the
    // low power modes; the other one is ignored. A wake returns to the run mode that
    // matches the source in effect, since the selection is kept across the halt.
    always @(posedge ref_clk) begin
        if (srst) begin
            op_mode <= `SCM_M_NORMAL;
        end else if (clk_en) begin
            case (op_mode)
                `SCM_M_NORMAL, `SCM_M_SLOW: begin
                    if (halt_req) begin
                        if (idle_on_halt_enable_q) begin
                            op_mode <= idle_sysclk_keep_q ? `SCM_M_IDLE1 : `SCM_M_IDLE0;
                        end else begin
                            op_mode <= wdt_enable_q ? `SCM_M_SLEEP1 : `SCM_M_SLEEP0;
                        end
                    end else if (sw_done) begin
                        op_mode <= tgt_fast ? `SCM_M_NORMAL : `SCM_M_SLOW;
                    end else begin
                        op_mode <= act_fast ? `SCM_M_NORMAL : `SCM_M_SLOW;
                    end
                end
                `SCM_M_IDLE0, `SCM_M_IDLE1, `SCM_M_SLEEP0, `SCM_M_SLEEP1: begin
                    if (wake_req) begin
                        op_mode <= act_fast ? `SCM_M_NORMAL : `SCM_M_SLOW;
                    end
                end
                default: begin
                    op_mode <= `SCM_M_NORMAL;
                end
            endcase
        end
    end

    // Oscillator enables and gated clock enables, all registered.
    // The enables are decided from the mode in effect, so they follow a mode change
    // one cycle later, except that a wake request with a fast source in effect raises the fast enable at the same edge.
    // The system and CPU enables stay low until the fast source is
    // ready again after a wake, which keeps an unsettled oscillator off the clock tree.
    always @(posedge ref_clk) begin
        if (srst) begin
            fast_osc_on <= 1'b1;
            slow_osc_on <= 1'b1;
            sys_clk_en  <= 1'b0;
            cpu_clk_en  <= 1'b0;
            tbc_clk_en  <= 1'b0;
            wdt_clk_en  <= 1'b0;
        end else if (clk_en) begin
            // Fast runs while it is the source in run or idle1, or a switch needs it.
            fast_osc_on <= (act_fast && (is_run || op_mode == `SCM_M_IDLE1))
                         || (sw_state_q != SW_IDLE && tgt_fast)
                         || (act_fast && wake_req && !is_run);
            // Slow oscillator stops only in sleep without watchdog.
            slow_osc_on <= (op_mode != `SCM_M_SLEEP0);
            // System clock runs in run modes and idle1, but not on the tick of the handover.
            sys_clk_en  <= cur_tick && !sw_done && (!act_fast || fast_ready_q)
                         && (is_run || op_mode == `SCM_M_IDLE1);
            cpu_clk_en  <= cur_tick && !sw_done && (!act_fast || fast_ready_q)
                         && is_run;
            // Time-base clock is the slow tick, stopped in both sleeps.
            tbc_clk_en  <= slow_tick && slow_ready_q && op_mode != `SCM_M_SLEEP0
                         && op_mode != `SCM_M_SLEEP1;
            // Watchdog counts from the slow clock, also in sleep with watchdog.
            wdt_clk_en  <= slow_tick && slow_ready_q && wdt_enable_q
                         && op_mode != `SCM_M_SLEEP0;
        end
    end

    // Software registers and sticky interrupt status; an event beats a read clear.
    // The status read clears in the address phase, at the same edge that captures the
    // read data, so an event in that cycle is kept for the next read instead of lost.
    // Writes to the ready flags, bit four and unmapped offsets have no effect.
    always @(posedge ref_clk) begin
        if (srst) begin
            sel_hl_q              <= `SCM_RST_HL;
            sel_cks_q             <= `SCM_RST_CKS;
            idle_on_halt_enable_q <= `SCM_RST_IDLE_EN;
            idle_sysclk_keep_q    <= 1'b0;
            wdt_enable_q          <= 1'b0;
            irq_mask_q            <= {`SCM_EV_W{1'b0}};
            irq_stat_q            <= {`SCM_EV_W{1'b0}};
            irq                   <= 1'b0;
        end else if (clk_en) begin
            if (dp_wr) begin
                case (dp_addr_q)
                    `SCM_ADDR_MODE: begin
                        sel_hl_q              <= hwdata[`SCM_BIT_HL];
                        idle_on_halt_enable_q <= hwdata[`SCM_BIT_IDLE_EN];
                        sel_cks_q             <= hwdata[`SCM_CKS_LSB+2:`SCM_CKS_LSB];
                    end
                    `SCM_ADDR_MODE1: begin
                        idle_sysclk_keep_q <= hwdata[`SCM_BIT_KEEP];
                        wdt_enable_q       <= hwdata[`SCM_BIT_WDT_EN];
                    end
                    `SCM_ADDR_IRQ_MASK: begin
                        irq_mask_q <= hwdata[`SCM_EV_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
            if (ap_read && haddr[7:0] == `SCM_ADDR_IRQ_STAT) begin
                irq_stat_q <= ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // AHB-Lite slave: zero wait states, read data registered in the address phase.
    // Only single word transfers are expected: the transfer size is not decoded and
    // only the low address byte selects a register. Unmapped offsets read zero and
    // every transfer completes with an OKAY response.
    always @(posedge ref_clk) begin
        if (srst) begin
            dp_write_q <= 1'b0;
            dp_addr_q  <= 8'h00;
            hrdata     <= 32'h00000000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else if (clk_en) begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            dp_write_q <= ap_valid & hwrite;
            dp_addr_q  <= haddr[7:0];
            if (ap_read) begin
                case (haddr[7:0])
                    `SCM_ADDR_MODE:     hrdata <= {24'h000000, mode_img};
                    `SCM_ADDR_MODE1:    hrdata <= {24'h000000, mode1_img};
                    `SCM_ADDR_IRQ_STAT: hrdata <= {29'h0000000, irq_stat_q};
                    `SCM_ADDR_IRQ_MASK: hrdata <= {29'h0000000, irq_mask_q};
                    `SCM_ADDR_STATE:    hrdata <= {24'h000000, state_img};
                    default:            hrdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* File: hdl/scm_consts.vh */
// Constants for the system clock and power mode controller.
`ifndef SCM_CONSTS_VH
`define SCM_CONSTS_VH

// Register byte addresses.
`define SCM_ADDR_MODE      8'h00
`define SCM_ADDR_MODE1     8'h04
`define SCM_ADDR_IRQ_STAT  8'h08
`define SCM_ADDR_IRQ_MASK  8'h0c
`define SCM_ADDR_STATE     8'h10

// Field positions of the clock mode control register.
`define SCM_BIT_HL         0
`define SCM_BIT_IDLE_EN    1
`define SCM_BIT_FAST_RDY   2
`define SCM_BIT_SLOW_RDY   3
`define SCM_CKS_LSB        5

// Field positions of the secondary mode register.
`define SCM_BIT_WDT_EN     0
`define SCM_BIT_KEEP       7

// Reset values.
`define SCM_RST_HL         1'b1
`define SCM_RST_IDLE_EN    1'b1
`define SCM_RST_CKS        3'h0

// Interrupt event bits.
`define SCM_EV_SWITCH      0
`define SCM_EV_FAST_RDY    1
`define SCM_EV_WAKE        2
`define SCM_EV_W           3

// Operating mode codes.
`define SCM_M_NORMAL       3'h0
`define SCM_M_SLOW         3'h1
`define SCM_M_IDLE0        3'h2
`define SCM_M_IDLE1        3'h3
`define SCM_M_SLEEP0       3'h4
`define SCM_M_SLEEP1       3'h5

// Whole current-clock periods counted before a source change.
`define SCM_SWITCH_TICKS   3'h4

`endif

/* File: verif/scm_ctrl_assertions.sv */
// Port-level checker for the clock and power mode controller.
`timescale 1ns/1ps
`default_nettype none
module scm_ctrl_checker (
    input wire logic       ref_clk,     // Clock.
    input wire logic       srst,        // Reset.
    input wire logic       clk_en,      // Clock enable.
    input wire logic       halt_req,    // Halt pulse.
    input wire logic       wake_req,    // Wake pulse.
    input wire logic [2:0] op_mode,     // Mode code.
    input wire logic       sys_clk_en,  // System tick.
    input wire logic       cpu_clk_en,  // CPU tick.
    input wire logic       tbc_clk_en,  // Time-base tick.
    input wire logic       wdt_clk_en,  // Watchdog tick.
    input wire logic       fast_osc_on, // Fast enable.
    input wire logic       slow_osc_on  // Slow enable.
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [2:0] prev_q;
    logic [1:0] hold_q;
    logic       calm;
    // Counts how long the mode code has stood, so gates and enables have settled.
    always @(posedge ref_clk) begin
        prev_q <= op_mode;
        hold_q <= (srst || op_mode != prev_q) ? 2'h0 : hold_q + {1'b0, hold_q != 2'h3};
    end
    assign calm = hold_q == 2'h3 && op_mode == prev_q;
    a_cpu_run_only: assert property (calm && op_mode >= 3'h2 |-> !cpu_clk_en)
        else $error("cpu tick while halted");
    a_sleep0_stops: assert property (calm && op_mode == 3'h4 |->
        !sys_clk_en && !tbc_clk_en && !wdt_clk_en && !slow_osc_on)
        else $error("clock alive in deep sleep");
    a_sleep1_keeps: assert property (calm && op_mode == 3'h5 |->
        slow_osc_on && !sys_clk_en && !tbc_clk_en)
        else $error("wrong clocks in watchdog sleep");
    a_idle0_stops: assert property (calm && op_mode == 3'h2 |->
        !sys_clk_en && slow_osc_on)
        else $error("wrong clocks in idle0");
    a_halt_enters: assert property (halt_req && clk_en && op_mode <= 3'h1 |=>
        op_mode >= 3'h2 && op_mode <= 3'h5)
        else $error("halt not taken");
    a_wake_returns: assert property (wake_req && clk_en && op_mode >= 3'h2 |=>
        op_mode <= 3'h1)
        else $error("wake not taken");
    a_tbc_from_slow: assert property (tbc_clk_en |-> slow_osc_on)
        else $error("time-base tick without slow source");
    a_normal_fast_on: assert property (calm && op_mode == 3'h0 |-> fast_osc_on)
        else $error("fast source off in normal mode");
endmodule
bind scm_ctrl scm_ctrl_checker chk_u (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .halt_req(halt_req), .wake_req(wake_req), .op_mode(op_mode), .sys_clk_en(sys_clk_en),
    .cpu_clk_en(cpu_clk_en), .tbc_clk_en(tbc_clk_en), .wdt_clk_en(wdt_clk_en),
    .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on));
`default_nettype wire

/* File: verif/scm_osc_model.sv */
// Behavioural model of the fast and slow RC oscillators.
`timescale 1ns/1ps
`default_nettype none
module scm_osc_model (
    input  wire logic ref_clk,    // Bench clock.
    input  wire logic fast_on,    // Fast enable.
    input  wire logic slow_on,    // Slow enable.
    output wire logic fast_osc,   // Fast wave, period 4 cycles.
    output wire logic slow_osc,   // Slow wave, period 32 cycles.
    output wire logic fast_stable // Fast source settled.
);
    int fc = 0;
    int sc = 0;
    // Age counters restart whenever a source is switched off.
    always @(posedge ref_clk) begin
        fc <= fast_on ? fc + 1 : 0;
        sc <= slow_on ? sc + 1 : 0;
    end
    // A stopped source rests low; the fast one needs more than 40 cycles to settle.
    assign fast_osc = fast_on && fc[1];
    assign slow_osc = slow_on && sc[4];
    assign fast_stable = fast_on && fc > 40;
endmodule
`default_nettype wire

/* File: verif/scm_ctrl_tb_top.sv */
// Self-checking bench for the clock and power mode controller.
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.vh"
module scm_ctrl_tb_top;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} scm_row_t;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        halt_req = 1'b0;
    logic        wake_req = 1'b0;
    logic [31:0] hrdata, q;
    logic        hreadyout, hresp, fosc, sosc, fstab, fon, son;
    logic        sys_en, cpu_en, tbc_en, wdt_en, irq;
    logic        clk_en = 1'b1;
    logic        fst;
    logic [2:0]  op_mode;
    logic [3:0]  act;
    logic [7:0]  prev;
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;
    int          c0, n, el, pc;
    logic [7:0]  cfg[9] = '{8'h42, 8'h62, 8'h82, 8'ha2, 8'hc2, 8'he2, 8'h02, 8'h22, 8'h03};
    logic [31:0] hc[4] = '{32'h00_03_02_02, 32'h80_03_03_06, 32'h00_01_04_00, 32'h01_01_05_01};
    scm_row_t    rows[8] = '{
        '{1'b0, `SCM_ADDR_MODE1, 32'h0, 32'h0},
        '{1'b0, `SCM_ADDR_STATE, 32'h0, 32'h8},
        '{1'b1, 8'h14, 32'hffffffff, 32'h0},
        '{1'b0, 8'h14, 32'h0, 32'h0},
        '{1'b1, `SCM_ADDR_MODE, 32'h1f, 32'h0},
        '{1'b0, `SCM_ADDR_MODE, 32'h0, 32'h0f},
        '{1'b1, `SCM_ADDR_IRQ_MASK, 32'h7, 32'h0},
        '{1'b0, `SCM_ADDR_IRQ_MASK, 32'h0, 32'h7}};

    // Free-running clock and a cycle count for measuring delays.
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    scm_ctrl dut_u (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fast_osc_in(fosc),
        .slow_osc_in(sosc), .fast_stable_in(fstab), .halt_req(halt_req), .wake_req(wake_req),
        .fast_osc_on(fon), .slow_osc_on(son), .sys_clk_en(sys_en), .cpu_clk_en(cpu_en),
        .tbc_clk_en(tbc_en), .wdt_clk_en(wdt_en), .op_mode(op_mode), .irq(irq));
    scm_osc_model osc_u (.ref_clk(ref_clk), .fast_on(fon), .slow_on(son), .fast_osc(fosc),
        .slow_osc(sosc), .fast_stable(fstab));

    // Compares one result and records a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // System tick period in cycles for a mode register value.
    function automatic int pexp(input logic [7:0] m);
        return m[0] ? 4 : (m[7:5] < 3'h2 ? 32 : 4 << (8 - m[7:5]));
    endfunction

    // Drives a one-cycle pulse on the halt or wake request.
    task automatic pulse(input logic h);
        @(posedge ref_clk);
        if (h) halt_req <= 1'b1; else wake_req <= 1'b1;
        @(posedge ref_clk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        #200000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end

    // Main sequence: registers, clock switching, halt and wake, second reset.
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        bus(1'b0, `SCM_ADDR_MODE, 32'h0, q);
        chk(q[2:0], 3'h3);
        repeat (100) @(posedge ref_clk);
        chk(irq, 1'b0);
        bus(1'b0, `SCM_ADDR_MODE, 32'h0, q);
        chk(q, 32'h0f);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, q);
            if (!rows[i].w) chk(q, rows[i].e);
            chk({hreadyout, hresp}, 2'h2);
        end
        chk(irq, 1'b1);
        bus(1'b0, `SCM_ADDR_IRQ_STAT, 32'h0, q);
        chk(q, 32'h2);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'b0);
        $display("register test done");
        prev = 8'h03;
        foreach (cfg[i]) begin
            pc = pexp(prev);
            bus(1'b1, `SCM_ADDR_MODE, {24'h0, cfg[i]}, q);
            c0 = cyc;
            do bus(1'b0, `SCM_ADDR_STATE, 32'h0, q); while (q[4] === 1'b1);
            el = cyc - c0;
            chk(el >= 4 * pc && el <= 6 * pc + pexp(cfg[i]) + 64, 1'b1);
            bus(1'b0, `SCM_ADDR_IRQ_STAT, 32'h0, q);
            chk(q[0], 1'b1);
            do @(posedge ref_clk); while (sys_en !== 1'b1);
            n = 0;
            do begin @(posedge ref_clk); n++; end while (sys_en !== 1'b1 && n < 600);
            chk(n, pexp(cfg[i]));
            fst = cfg[i][0] || cfg[i][7:6] != 2'h0;
            chk({fon, op_mode}, {fst, 2'h0, !fst});
            prev = cfg[i];
        end
        $display("switch test done");
        foreach (hc[i]) begin
            bus(1'b1, `SCM_ADDR_MODE1, {24'h0, hc[i][31:24]}, q);
            bus(1'b1, `SCM_ADDR_MODE, {24'h0, hc[i][23:16]}, q);
            pulse(1'b1);
            repeat (4) @(posedge ref_clk);
            act = 4'h0;
            repeat (96) begin
                @(posedge ref_clk);
                act = act | {cpu_en, sys_en, tbc_en, wdt_en};
            end
            chk(op_mode, hc[i][10:8]);
            chk(act, hc[i][3:0]);
            bus(1'b0, `SCM_ADDR_MODE, 32'h0, q);
            chk(q[3], hc[i][10:8] != 3'h4);
            pulse(1'b0);
            repeat (58) @(posedge ref_clk);
            bus(1'b0, `SCM_ADDR_MODE, 32'h0, q);
            chk(q[3], 1'b1);
        end
        $display("halt test done");
        clk_en <= 1'b0;
        pulse(1'b1);
        repeat (2) @(posedge ref_clk);
        chk(op_mode, 3'h0);
        clk_en <= 1'b1;
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        chk({fon, son, op_mode}, 5'h18);
        $display("reset test done");
        close_out();
    end
endmodule
`default_nettype wire
